// [rtl/sscirq_pkg.sv]
// package: register map, field positions and types of the system control / irq block
package sscirq_pkg;
	localparam logic [7:0] ADDR_SYS_CTRL_TWO   = 8'h2B;
	localparam logic [7:0] ADDR_WAKE_PIN_CFG   = 8'h2C;
	localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h2D;
	localparam logic [7:0] ADDR_IRQ_ROUTE      = 8'h2E;
	localparam logic [7:0] ADDR_IRQ_SOURCE     = 8'h0C;
	// system_control_two fields
	localparam int BIT_SELF_CHECK   = 7;
	localparam int BIT_SOFT_RESET   = 6;
	localparam int BIT_DOZE_ENABLE  = 2;
	localparam int SLEEP_OS_LSB     = 3;
	localparam int WAKE_OS_LSB      = 0;
	// wake_source_and_pin_config fields
	localparam int BIT_IRQ_POLARITY = 1;
	localparam int BIT_IRQ_DRIVE    = 0;
	// source bit positions shared by enable, routing and source registers
	localparam int SRC_DOZE   = 7;
	localparam int SRC_TRANS  = 5;
	localparam int SRC_ORIENT = 4;
	localparam int SRC_PULSE  = 3;
	localparam int SRC_FALL   = 2;
	localparam int SRC_READY  = 0;
	// writable masks; unused positions read as zero
	localparam logic [7:0] MASK_SYS_CTRL_TWO = 8'h9F;
	localparam logic [7:0] MASK_WAKE_PIN_CFG = 8'h7B;
	localparam logic [7:0] MASK_IRQ_SRC      = 8'hBD;
	localparam logic [7:0] RESET_VALUE       = 8'h00;
	// wake register holds detector wake bits one place above the source bits
	localparam int WAKE_SHIFT = 1;
	// boot sequence length after a soft reset, in clock cycles
	localparam logic [3:0] BOOT_CYCLES = 4'h8;
	localparam logic [2:0] OS_RATIO_LOG_FAST = 3'h1;

	typedef enum logic [1:0] {
		OS_NORMAL    = 2'h0,
		OS_LOW_NOISE = 2'h1,
		OS_HIGH_RES  = 2'h2,
		OS_LOW_POWER = 2'h3
	} sscirq_os_e;

	typedef enum logic [1:0] {
		ST_RUN   = 2'h0,
		ST_BOOT  = 2'h1
	} sscirq_boot_e;

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sscirq_bus_s;

	typedef struct packed {
		logic       doze;
		logic       trans;
		logic       orient;
		logic       pulse;
		logic       fall;
		logic       ready;
	} sscirq_flags_s;
endpackage : sscirq_pkg

// [rtl/sscirq_pin_drive.sv]
// one interrupt pin driver: polarity and push-pull or open-drain selection
`timescale 1ns/1ps
`default_nettype none
module sscirq_pin_drive
	import sscirq_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic active,
	input  wire logic polarityHigh,
	input  wire logic openDrain,
	output var  logic pinOut,
	output var  logic pinOe
);
	typedef struct packed {
		logic pinOut;
		logic pinOe;
	} sscirq_pin_s;
	sscirq_pin_s state_reg;
	sscirq_pin_s state_next;
	logic        level;

	always_comb begin
		level = active ? polarityHigh : ~polarityHigh;
		state_next.pinOut = level;
		if (openDrain) begin
			// open drain only pulls low; the high level comes from the pull-up
			state_next.pinOut = 1'b0;
			state_next.pinOe  = ~level;
		end else begin
			state_next.pinOe  = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{pinOut: 1'b1, pinOe: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign pinOut = state_reg.pinOut;
	assign pinOe  = state_reg.pinOe;
endmodule : sscirq_pin_drive
`default_nettype wire

// [rtl/sscirq_top.sv]
// system control and interrupt routing block of a three-axis motion sensor
// Summary of operation
// - self-check bit applies stimulus to axis outputs
// - soft reset reloads every register default
// - soft reset also resets serial interface
// - reset bit never stored, reads zero even during boot
// - auto-doze bit gates automatic sleep entry
// - separate wake and sleep oversample selectors
// - selector encoding fixed, both reset to normal
// - averaging ratio from scheme and data rate
// - wake-source bits let detectors wake system
// - polarity bit selects asserted pin level
// - drive bit selects push-pull or open drain
// - six enables gate flags into controller
// - routing bit one pin a, zero pin b
// - doze switches oversample mode after inactivity period
// - doze and ready never wake nor restart
// - each doze transition except the soft-reset exit raises doze interrupt
`timescale 1ns/1ps
`default_nettype none
module sscirq_top
	import sscirq_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire sscirq_bus_s   bus,
	output var  logic [7:0]    rdata,
	output var  logic          serialReset,
	input  wire sscirq_flags_s detFlags,
	input  wire logic          inactivityExpired,
	input  wire logic [2:0]    rateSel,
	output var  logic          selfCheckActive,
	output var  logic          dozeActive,
	output var  logic          inactivityRestart,
	output var  logic [1:0]    activeOversample,
	output var  logic [3:0]    avgRatioLog2,
	output var  logic          irq_pin_a_out,
	output var  logic          irq_pin_a_oe,
	output var  logic          irq_pin_b_out,
	output var  logic          irq_pin_b_oe
);
	typedef struct packed {
		logic [7:0]   ctrlTwo;
		logic [7:0]   wakeCfg;
		logic [7:0]   irqEnable;
		logic [7:0]   irqRoute;
		logic [7:0]   rdata;
		sscirq_boot_e boot;
		logic [3:0]   bootCnt;
		logic         serialReset;
		logic         doze;
		logic         dozeEvent;
		logic         restart;
		logic         pinA;
		logic         pinB;
		logic [3:0]   ratioLog;
		logic [1:0]   osAct;
	} sscirq_state_s;

	sscirq_state_s state_reg;
	sscirq_state_s state_next;
	logic [7:0]    srcVec;
	logic [7:0]    srcActive;
	logic          wakeHit;
	logic          activity;
	logic [1:0]    osSel;

	// log2 of averaging ratio; lowest rate and fastest rate are the anchors
	function automatic logic [3:0] ratio_log(input logic [1:0] os, input logic [2:0] dr);
		logic [3:0] r;
		r = 4'h1;
		if (dr == 3'h0) begin
			r = {1'b0, OS_RATIO_LOG_FAST};
		end else if (dr == 3'h7) begin
			case (sscirq_os_e'(os))
				OS_NORMAL:    r = 4'h7;
				OS_LOW_NOISE: r = 4'h5;
				OS_HIGH_RES:  r = 4'hA;
				default:      r = 4'h4;
			endcase
		end else begin
			case (sscirq_os_e'(os))
				OS_HIGH_RES:  r = 4'h9 - {1'b0, dr};
				OS_LOW_POWER: r = 4'h1;
				default:      r = 4'h2;
			endcase
		end
		return r;
	endfunction : ratio_log

	always_comb begin
		srcVec = 8'h00;
		srcVec[SRC_DOZE]   = state_reg.dozeEvent;
		srcVec[SRC_TRANS]  = detFlags.trans;
		srcVec[SRC_ORIENT] = detFlags.orient;
		srcVec[SRC_PULSE]  = detFlags.pulse;
		srcVec[SRC_FALL]   = detFlags.fall;
		srcVec[SRC_READY]  = detFlags.ready;
		srcActive = srcVec & state_reg.irqEnable & MASK_IRQ_SRC;
		wakeHit = |(srcActive[SRC_TRANS:SRC_FALL]
			& state_reg.wakeCfg[SRC_TRANS+WAKE_SHIFT:SRC_FALL+WAKE_SHIFT]);
		activity = |srcActive[SRC_TRANS:SRC_FALL];
		osSel = state_reg.doze ? state_reg.ctrlTwo[SLEEP_OS_LSB +: 2]
			: state_reg.ctrlTwo[WAKE_OS_LSB +: 2];
	end

	always_comb begin
		state_next = state_reg;
		state_next.restart   = 1'b0;
		state_next.dozeEvent = state_reg.dozeEvent;
		if (!state_reg.doze && state_reg.ctrlTwo[BIT_DOZE_ENABLE] && inactivityExpired
			&& !activity) begin
			state_next.doze = 1'b1;
		end else if (state_reg.doze && (wakeHit || !state_reg.ctrlTwo[BIT_DOZE_ENABLE])) begin
			state_next.doze = 1'b0;
		end
		if (state_next.doze != state_reg.doze) begin
			state_next.dozeEvent = 1'b1;
		end
		state_next.restart = activity;
		state_next.ratioLog = ratio_log(osSel, rateSel);
		state_next.pinA = |(srcActive & state_reg.irqRoute);
		state_next.pinB = |(srcActive & ~state_reg.irqRoute);
		state_next.rdata = state_reg.rdata;
		if (bus.rdEn) begin
			case (bus.addr)
				ADDR_SYS_CTRL_TWO: state_next.rdata = state_reg.ctrlTwo & MASK_SYS_CTRL_TWO;
				ADDR_WAKE_PIN_CFG: state_next.rdata = state_reg.wakeCfg & MASK_WAKE_PIN_CFG;
				ADDR_IRQ_ENABLE:   state_next.rdata = state_reg.irqEnable & MASK_IRQ_SRC;
				ADDR_IRQ_ROUTE:    state_next.rdata = state_reg.irqRoute & MASK_IRQ_SRC;
				ADDR_IRQ_SOURCE:   state_next.rdata = srcActive;
				default:           state_next.rdata = RESET_VALUE;
			endcase
			// reading the source register acknowledges the doze event
			if (bus.addr == ADDR_IRQ_SOURCE && state_next.doze == state_reg.doze) begin
				state_next.dozeEvent = 1'b0;
			end
		end
		case (state_reg.boot)
			ST_BOOT: begin
				state_next.serialReset = 1'b1;
				state_next.bootCnt     = state_reg.bootCnt - 4'h1;
				if (state_reg.bootCnt == 4'h1) begin
					state_next.boot        = ST_RUN;
					state_next.serialReset = 1'b0;
				end
			end
			ST_RUN: begin
				if (bus.wrEn) begin
					case (bus.addr)
						ADDR_SYS_CTRL_TWO: begin
							state_next.ctrlTwo = bus.wdata & MASK_SYS_CTRL_TWO;
						end
						ADDR_WAKE_PIN_CFG: state_next.wakeCfg = bus.wdata & MASK_WAKE_PIN_CFG;
						ADDR_IRQ_ENABLE:   state_next.irqEnable = bus.wdata & MASK_IRQ_SRC;
						ADDR_IRQ_ROUTE:    state_next.irqRoute = bus.wdata & MASK_IRQ_SRC;
						default:           state_next.ctrlTwo = state_reg.ctrlTwo;
					endcase
					if (bus.addr == ADDR_SYS_CTRL_TWO && bus.wdata[BIT_SOFT_RESET]) begin
						state_next.ctrlTwo     = RESET_VALUE;
						state_next.wakeCfg     = RESET_VALUE;
						state_next.irqEnable   = RESET_VALUE;
						state_next.irqRoute    = RESET_VALUE;
						state_next.doze        = 1'b0;
						state_next.dozeEvent   = 1'b0;
						state_next.boot        = ST_BOOT;
						state_next.bootCnt     = BOOT_CYCLES;
						state_next.serialReset = 1'b1;
						state_next.pinA        = 1'b0;
						state_next.pinB        = 1'b0;
					end
				end
			end
			default: state_next.boot = ST_RUN;
		endcase
		// selector of the coming state, registered so the port is a flop
		state_next.osAct = state_next.doze ? state_next.ctrlTwo[SLEEP_OS_LSB +: 2]
			: state_next.ctrlTwo[WAKE_OS_LSB +: 2];
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{ctrlTwo: 8'h00, wakeCfg: 8'h00, irqEnable: 8'h00, irqRoute: 8'h00,
				rdata: 8'h00, boot: ST_RUN, bootCnt: 4'h0, serialReset: 1'b0, doze: 1'b0,
				dozeEvent: 1'b0, restart: 1'b0, pinA: 1'b0, pinB: 1'b0, ratioLog: 4'h1,
				osAct: 2'h0};
		end else begin
			state_reg <= state_next;
		end
	end

	// pin drivers are registered, so the pins lag the internal request by one cycle
	sscirq_pin_drive uPinA (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.active       (state_reg.pinA),
		.polarityHigh (state_reg.wakeCfg[BIT_IRQ_POLARITY]),
		.openDrain    (state_reg.wakeCfg[BIT_IRQ_DRIVE]),
		.pinOut       (irq_pin_a_out),
		.pinOe        (irq_pin_a_oe)
	);
	sscirq_pin_drive uPinB (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.active       (state_reg.pinB),
		.polarityHigh (state_reg.wakeCfg[BIT_IRQ_POLARITY]),
		.openDrain    (state_reg.wakeCfg[BIT_IRQ_DRIVE]),
		.pinOut       (irq_pin_b_out),
		.pinOe        (irq_pin_b_oe)
	);

	assign rdata             = state_reg.rdata;
	assign serialReset       = state_reg.serialReset;
	assign selfCheckActive   = state_reg.ctrlTwo[BIT_SELF_CHECK];
	assign dozeActive        = state_reg.doze;
	assign inactivityRestart = state_reg.restart;
	assign activeOversample  = state_reg.osAct;
	assign avgRatioLog2      = state_reg.ratioLog;

	AST_RST_SELF_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
		bus.wrEn && bus.addr == ADDR_SYS_CTRL_TWO && bus.wdata[BIT_SOFT_RESET]
		&& state_reg.boot == ST_RUN |=> state_reg.ctrlTwo == 8'h00 && serialReset)
		else $error("soft reset did not clear control");
	AST_SERIAL_RELEASE: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(serialReset) |-> serialReset [*8] ##1 !serialReset)
		else $error("serial reset length wrong");
	AST_PIN_A: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.pinA && !state_reg.wakeCfg[BIT_IRQ_DRIVE]
		|=> irq_pin_a_out == $past(state_reg.wakeCfg[BIT_IRQ_POLARITY]))
		else $error("pin a level wrong");
	AST_ROUTE_B: assert property (@(posedge clk_sys) disable iff (!rstn)
		detFlags.ready && state_reg.irqEnable[SRC_READY] && !state_reg.irqRoute[SRC_READY]
		&& !(bus.wrEn && bus.addr == ADDR_SYS_CTRL_TWO && bus.wdata[BIT_SOFT_RESET])
		|=> state_reg.pinB)
		else $error("pin b routing wrong");
	AST_ENABLE_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
		(srcVec & state_reg.irqEnable) == 8'h00 |=> !state_reg.pinA && !state_reg.pinB)
		else $error("disabled source reached controller");
	AST_NO_DOZE: assert property (@(posedge clk_sys) disable iff (!rstn)
		!state_reg.ctrlTwo[BIT_DOZE_ENABLE] |=> !dozeActive)
		else $error("doze without enable");
	AST_DOZE_EVENT: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(dozeActive) && state_reg.boot == ST_RUN |-> state_reg.dozeEvent)
		else $error("doze transition lost");
	AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.wakeCfg[BIT_IRQ_DRIVE] && $stable(state_reg.wakeCfg) |=> !irq_pin_a_out)
		else $error("open drain drove high");
	AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_reg.wakeCfg & ~MASK_WAKE_PIN_CFG) == 8'h00)
		else $error("reserved bit stored");
	AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rstn)
		inactivityRestart |-> $past(activity))
		else $error("restart without detector");

	COV_SOFT_RESET: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(serialReset));
	COV_DOZE: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(dozeActive));
	COV_WAKE: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(dozeActive));
	COV_BOTH_PINS: cover property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.pinA && state_reg.pinB);
endmodule : sscirq_top
`default_nettype wire

// [testbench/sscirq_host_model.sv]
// host side of the interrupt lines: pull-up resolution of each shared wire
`timescale 1ns/1ps
`default_nettype none
module sscirq_host_model
	import sscirq_pkg::*;
(
	input  wire logic pinAOut,
	input  wire logic pinAOe,
	input  wire logic pinBOut,
	input  wire logic pinBOe,
	output var  logic lineA,
	output var  logic lineB
);
	// pull-up when released
	// an undriven open-drain line must not read as the last driven value
	always_comb begin
		lineA = pinAOe ? pinAOut : 1'b1;
		lineB = pinBOe ? pinBOut : 1'b1;
	end
endmodule : sscirq_host_model
`default_nettype wire

// [testbench/sscirq_top_bench.sv]
// self-checking bench of the system control and interrupt routing block
`timescale 1ns/1ps
`default_nettype none
module sscirq_top_bench
	import sscirq_pkg::*;
;
	logic          clk_sys, rstn, inact, serRst, selfChk, doze, restart, aOut, aOe, bOut, bOe;
	logic          lineA, lineB;
	logic [2:0]    rate;
	logic [1:0]    osSel;
	logic [3:0]    ratio;
	logic [7:0]    rdata, v, w;
	sscirq_bus_s   busIn;
	sscirq_flags_s flags;
	int            err_total, checked, seed, srcPos[5];
	bit            en, rt;

	sscirq_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .bus(busIn), .rdata(rdata),
		.serialReset(serRst), .detFlags(flags), .inactivityExpired(inact), .rateSel(rate),
		.selfCheckActive(selfChk), .dozeActive(doze), .inactivityRestart(restart),
		.activeOversample(osSel), .avgRatioLog2(ratio), .irq_pin_a_out(aOut),
		.irq_pin_a_oe(aOe), .irq_pin_b_out(bOut), .irq_pin_b_oe(bOe));
	sscirq_host_model host_u (.pinAOut(aOut), .pinAOe(aOe), .pinBOut(bOut), .pinBOe(bOe),
		.lineA(lineA), .lineB(lineB));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		busIn = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
		@(negedge clk_sys);
		busIn.wrEn = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		busIn = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		busIn.rdEn = 1'b0;
		@(negedge clk_sys);
		d = rdata;
	endtask : rd

	task automatic waitDoze(input logic want);
		int n;
		for (n = 0; n < 40 && doze !== want; n++) @(negedge clk_sys);
		if (doze !== want) begin
			err_total++;
			$display("ERROR t=%0t doze state wait ran out", $time);
			final_report();
		end
	endtask : waitDoze

	function automatic logic [7:0] maskOf(input logic [7:0] a);
		return (a == ADDR_SYS_CTRL_TWO) ? MASK_SYS_CTRL_TWO & 8'hBF :
			(a == ADDR_WAKE_PIN_CFG) ? MASK_WAKE_PIN_CFG : MASK_IRQ_SRC;
	endfunction : maskOf

	function automatic logic [3:0] ratioOf(input logic [1:0] m, input logic [2:0] r);
		if (r == 3'h0) return 4'h1;
		case (m)
			2'h0: return 4'h7;
			2'h1: return 4'h5;
			2'h2: return 4'hA;
			default: return 4'h4;
		endcase
	endfunction : ratioOf

	initial begin
		seed = 64;
		srcPos = '{0, 2, 3, 4, 5};
		err_total = 0;
		checked = 0;
		rstn = 1'b0;
		busIn = '0;
		flags = '0;
		inact = 1'b0;
		rate = 3'h0;
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		for (int a = 8'h2B; a <= 8'h2E; a++) begin
			rd(8'(a), v);
			check(v, RESET_VALUE);
		end
		check(8'({aOut, aOe, bOut, bOe}), 8'h0F);
		repeat (8) begin
			for (int a = 8'h2C; a <= 8'h2E; a++) begin
				v = 8'($random(seed));
				wr(8'(a), v);
				rd(8'(a), w);
				check(w, v & maskOf(8'(a)));
			end
			v = 8'($random(seed)) & 8'hBF;
			wr(ADDR_SYS_CTRL_TWO, v);
			rd(ADDR_SYS_CTRL_TWO, w);
			check(w, v & maskOf(ADDR_SYS_CTRL_TWO));
			check(8'(selfChk), 8'(v[BIT_SELF_CHECK]));
		end
		// averaging per scheme at both rate anchors
		for (int m = 0; m < 4; m++) begin
			for (int r = 0; r < 8; r += 7) begin
				wr(ADDR_SYS_CTRL_TWO, 8'(m));
				rate = 3'(r);
				repeat (3) @(negedge clk_sys);
				check(8'(osSel), 8'(m));
				check(8'(ratio), 8'(ratioOf(2'(m), 3'(r))));
			end
		end
		// random enable and route per detector source
		wr(ADDR_WAKE_PIN_CFG, 8'h00);
		for (int k = 0; k < 5; k++) begin
			en = 1'($random(seed));
			rt = 1'($random(seed));
			wr(ADDR_IRQ_ENABLE, 8'(en) << srcPos[k]);
			wr(ADDR_IRQ_ROUTE, 8'(rt) << srcPos[k]);
			flags = 6'(1 << k);
			repeat (4) @(negedge clk_sys);
			check(8'({lineA, lineB}), 8'({~(en & rt), ~(en & ~rt)}));
			flags = '0;
			repeat (4) @(negedge clk_sys);
			check(8'({lineA, lineB}), 8'h03);
		end
		wr(ADDR_IRQ_ENABLE, 8'h01);
		wr(ADDR_IRQ_ROUTE, 8'h00);
		for (int c = 1; c < 3; c++) begin
			wr(ADDR_WAKE_PIN_CFG, 8'(c));
			flags.ready = 1'b1;
			repeat (4) @(negedge clk_sys);
			check(8'(lineB), 8'(c == 2));
			flags.ready = 1'b0;
			repeat (4) @(negedge clk_sys);
			check(8'(lineB), 8'(c == 1));
			check(8'(bOe), 8'(c == 2));
		end
		wr(ADDR_WAKE_PIN_CFG, 8'h08);
		wr(ADDR_IRQ_ENABLE, 8'h85);
		wr(ADDR_IRQ_ROUTE, 8'h80);
		wr(ADDR_SYS_CTRL_TWO, 8'h11);
		inact = 1'b1;
		repeat (6) @(negedge clk_sys);
		check(8'(doze), 8'h00);
		wr(ADDR_SYS_CTRL_TWO, 8'h15);
		waitDoze(1'b1);
		check(8'(osSel), 8'h02);
		repeat (3) @(negedge clk_sys);
		check(8'(lineA), 8'h00);
		inact = 1'b0;
		flags.ready = 1'b1;
		repeat (6) @(negedge clk_sys);
		check(8'({doze, restart}), 8'h02);
		rd(ADDR_IRQ_SOURCE, v);
		check(v, 8'h81);
		flags = '0;
		flags.fall = 1'b1;
		waitDoze(1'b0);
		check(8'(osSel), 8'h01);
		check(8'(restart), 8'h01);
		flags = '0;
		// soft reset, writes refused in boot
		wr(ADDR_IRQ_ENABLE, 8'hFF);
		wr(ADDR_SYS_CTRL_TWO, 8'hC0);
		check(8'({serRst, selfChk}), 8'h02);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		repeat (10) @(negedge clk_sys);
		check(8'(serRst), 8'h00);
		rd(ADDR_SYS_CTRL_TWO, v);
		check(v, 8'h00);
		rd(ADDR_IRQ_ENABLE, v);
		check(v, 8'h00);
		// hardware reset in mid-run brings defaults back
		wr(ADDR_WAKE_PIN_CFG, 8'h7B);
		rstn = 1'b0;
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		rd(ADDR_WAKE_PIN_CFG, v);
		check(v, RESET_VALUE);
		check(8'({aOut, aOe, bOut, bOe}), 8'h0F);
		final_report();
	end
endmodule : sscirq_top_bench
`default_nettype wire
